// file: logic/card_reset_ctrl.sv
// Card side reset, answer-to-reset, PPS and clock-stop supervision
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "card_ctrl_defs.svh"
module card_reset_ctrl #(
    parameter int STOP_IDLE_CYC = 32
) (
    // Clock, reset, enable
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    // Card contacts
    input  wire logic                     cardVcc,
    input  wire logic                     cardRstN,
    input  wire logic                     cardClk,
    // Character layer
    input  wire card_ctrl_pkg::rxChar_s   rxChar,
    input  wire logic                     txReady,
    input  wire logic                     txDone,
    output logic                          txValid,
    output logic [7:0]                    txData,
    output logic                          parityCheckEn,
    // Protocol layer
    output logic                          protoActive,
    output logic                          securityClear,
    output logic                          cmdValid,
    output logic [7:0]                    cmdData,
    output card_ctrl_pkg::linkCfg_s       linkCfg,
    // Register port
    input  wire logic [7:0]               regAddr,
    input  wire logic [31:0]              regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic [31:0]                   regRdata
);
    import card_ctrl_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] clkInd(input logic [7:0] c);
        // Classes beyond A force a clock-stop capability into the indication
        if (c[7:6] == 2'h0 && c[5:0] != `CLASS_A_ONLY) return {2'h1, c[5:0]};
        return c;
    endfunction : clkInd
    function automatic logic [7:0] atrByte(input logic [3:0] i, input logic [7:0] ta1,
                                           input logic [7:0] ta3, input logic [7:0] tb3);
        logic [7:0] tck;
        tck = `ATR_T0 ^ ta1 ^ `ATR_TD1 ^ `ATR_TD2 ^ clkInd(ta3) ^ tb3;
        case (i)
            4'h0:    return `ATR_TS;
            4'h1:    return `ATR_T0;
            4'h2:    return ta1;
            4'h3:    return `ATR_TD1;
            4'h4:    return `ATR_TD2;
            4'h5:    return clkInd(ta3);
            4'h6:    return tb3;
            default: return tck;
        endcase
    endfunction : atrByte
    function automatic logic fidiOk(input logic [7:0] p, input logic [7:0] ta1);
        return p == `DEF_FIDI || p == ta1 || p == `FIDI_512_8 || p == `FIDI_512_16;
    endfunction : fidiOk
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] vccS, rstS, clkS;
    logic       clkD;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vccS <= 2'h0;
            rstS <= 2'h0;
            clkS <= 2'h0;
            clkD <= 1'b0;
        end else if (ce) begin
            vccS <= {vccS[0], cardVcc};
            rstS <= {rstS[0], cardRstN};
            clkS <= {clkS[0], cardClk};
            clkD <= clkS[1];
        end
    end
    wire logic vccOn   = vccS[1];
    wire logic rstHi   = rstS[1];
    wire logic clkRise = clkS[1] & ~clkD;
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic       ctrlSpec, next_ctrlSpec, coldPend, next_coldPend;
    ctrlState_e state, next_state;
    logic [7:0] ta1R, ta3R, tb3R, next_ta1R, next_ta3R, next_tb3R;
    logic       ppsGood, ppsBad, stopEarly, stopForbid, cmdEarly;
    logic [31:0] next_regRdata;
    wire logic  wrStat = regWr && regAddr == `OFS_STAT;
    always_comb begin
        next_ctrlSpec = ctrlSpec;
        next_ta1R     = ta1R;
        next_ta3R     = ta3R;
        next_tb3R     = tb3R;
        if (regWr) begin
            case (regAddr)
                `OFS_CTRL:   next_ctrlSpec = regWdata[0];
                `OFS_TA1:    next_ta1R     = regWdata[7:0];
                `OFS_CLKCLS: next_ta3R     = regWdata[7:0];
                `OFS_FEAT:   next_tb3R     = regWdata[7:0];
                default:     next_ctrlSpec = ctrlSpec;
            endcase
        end
        next_regRdata = 32'h0;
        if (regRd) begin
            case (regAddr)
                `OFS_CTRL:   next_regRdata = {31'h0, ctrlSpec};
                `OFS_TA1:    next_regRdata = {24'h0, ta1R};
                `OFS_CLKCLS: next_regRdata = {24'h0, ta3R};
                `OFS_FEAT:   next_regRdata = {24'h0, tb3R};
                `OFS_STAT:   next_regRdata = {21'h0, 3'(state), cmdEarly, stopForbid, stopEarly,
                                              ppsBad, ppsGood, protoActive, linkCfg.specific, coldPend};
                `OFS_NEG:    next_regRdata = {16'h0, linkCfg.fiDi, linkCfg.features};
                default:     next_regRdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlSpec <= 1'b0;
            ta1R     <= `RST_TA1;
            ta3R     <= `RST_CLKCLS;
            tb3R     <= `RST_FEAT;
            regRdata <= 32'h0;
        end else if (ce) begin
            ctrlSpec <= next_ctrlSpec;
            ta1R     <= next_ta1R;
            ta3R     <= next_ta3R;
            tb3R     <= next_tb3R;
            regRdata <= next_regRdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Reset, answer-to-reset and PPS sequencing
    logic       txPps, next_txPps;
    logic [3:0] idx, next_idx, txLen, next_txLen;
    logic [7:0] ta1S, ta3S, tb3S, next_ta1S, next_ta3S, next_tb3S;
    logic [7:0] ppsBuf [0:5], next_ppsBuf [0:5];
    logic [2:0] ppsCnt, next_ppsCnt, ppsLen, next_ppsLen;
    logic       next_txValid, next_protoActive, next_securityClear, next_cmdValid;
    logic       next_ppsGood, next_ppsBad, ok;
    logic [7:0] next_txData, next_cmdData, chk;
    linkCfg_s   next_linkCfg;
    wire logic  rxOk = rxChar.valid && !rxChar.parityErr;
    always_comb begin
        next_state = state; next_coldPend = coldPend; next_txPps = txPps;
        next_idx = idx; next_txLen = txLen; next_ppsCnt = ppsCnt; next_ppsLen = ppsLen;
        next_ta1S = ta1S; next_ta3S = ta3S; next_tb3S = tb3S;
        next_ppsBuf = ppsBuf; next_linkCfg = linkCfg;
        next_txValid = txValid; next_txData = txData; next_protoActive = protoActive;
        next_securityClear = 1'b0; next_cmdValid = 1'b0; next_cmdData = cmdData;
        next_ppsGood = ppsGood & ~(wrStat & regWdata[3]);
        next_ppsBad  = ppsBad & ~(wrStat & regWdata[4]);
        chk = rxChar.data;
        ok = 1'b0;
        if (!vccOn || !rstHi) begin
            next_coldPend = coldPend | ~vccOn;
            next_state = ST_HELD;
            next_txValid = 1'b0;
            next_protoActive = 1'b0;
        end else begin
            unique case (state)
                ST_HELD: begin
                    next_securityClear = 1'b1;
                    if (coldPend) begin
                        // Configuration is frozen per session so warm resets repeat it
                        next_ta1S = ta1R; next_ta3S = ta3R; next_tb3S = tb3R;
                        next_coldPend = 1'b0;
                        next_linkCfg = '{specific: 1'b0, fiDi: `DEF_FIDI, features: 8'h00};
                    end else begin
                        next_linkCfg.specific = ctrlSpec;
                        if (!ctrlSpec) begin
                            next_linkCfg.fiDi = `DEF_FIDI;
                            next_linkCfg.features = 8'h00;
                        end
                    end
                    next_state = ST_SEND; next_txPps = 1'b0; next_idx = 4'h0; next_txLen = `ATR_LEN;
                    next_txValid = 1'b1; next_txData = `ATR_TS;
                end
                ST_SEND: if (txValid && txReady) begin
                    if (idx + 4'h1 == txLen) begin
                        next_txValid = 1'b0;
                        if (txPps || linkCfg.specific) begin
                            next_state = ST_ACTIVE; next_protoActive = 1'b1;
                        end else begin
                            next_state = ST_FIRST;
                        end
                    end else begin
                        next_idx = idx + 4'h1;
                        next_txData = txPps ? ppsBuf[3'(idx + 4'h1)] : atrByte(idx + 4'h1, ta1S, ta3S, tb3S);
                    end
                end
                ST_FIRST: if (rxOk) begin
                    if (rxChar.data == `PPSS_CODE) begin
                        next_ppsBuf[0] = rxChar.data; next_ppsCnt = 3'h1; next_ppsLen = 3'h6;
                        next_state = ST_PPS;
                    end else begin
                        // No PPS: defaults stay and the byte is the first command byte
                        next_state = ST_ACTIVE; next_protoActive = 1'b1;
                        next_cmdValid = 1'b1; next_cmdData = rxChar.data;
                    end
                end
                ST_PPS: if (rxOk) begin
                    next_ppsBuf[ppsCnt] = rxChar.data;
                    if (ppsCnt == 3'h1)
                        next_ppsLen = 3'(rxChar.data[4]) + 3'(rxChar.data[5]) + 3'(rxChar.data[6]) + 3'h3;
                    for (int i = 0; i < 6; i++)
                        if (3'(i) < ppsCnt) chk = chk ^ ppsBuf[i];
                    if (ppsCnt + 3'h1 == next_ppsLen) begin
                        ok = chk == 8'h00 && ppsBuf[1][3:0] == 4'h0
                             && (!ppsBuf[1][4] || fidiOk(ppsBuf[2], ta1S))
                             && (!ppsBuf[1][5] || (next_ppsBuf[ppsBuf[1][4] ? 3 : 2] & ~tb3S) == 8'h00);
                        if (ok) begin
                            next_linkCfg.fiDi = ppsBuf[1][4] ? ppsBuf[2] : `DEF_FIDI;
                            next_linkCfg.features = ppsBuf[1][5] ? next_ppsBuf[ppsBuf[1][4] ? 3 : 2] : 8'h00;
                            next_ppsGood = 1'b1; next_txPps = 1'b1; next_idx = 4'h0;
                            next_txLen = {1'b0, next_ppsLen}; next_txValid = 1'b1;
                            next_txData = `PPSS_CODE; next_state = ST_SEND;
                        end else begin
                            // A refused request is answered by silence; the terminal resets
                            next_ppsBad = 1'b1; next_state = ST_MUTE;
                        end
                    end else begin
                        next_ppsCnt = ppsCnt + 3'h1;
                    end
                end
                ST_MUTE: next_state = ST_MUTE;
                ST_ACTIVE: if (rxOk) begin
                    next_cmdValid = 1'b1; next_cmdData = rxChar.data;
                end
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_HELD; coldPend <= 1'b1; txPps <= 1'b0; idx <= 4'h0; txLen <= 4'h0;
            ta1S <= `RST_TA1; ta3S <= `RST_CLKCLS; tb3S <= `RST_FEAT;
            for (int i = 0; i < 6; i++) ppsBuf[i] <= 8'h00;
            ppsCnt <= 3'h0; ppsLen <= 3'h0;
            linkCfg <= '{specific: 1'b0, fiDi: `DEF_FIDI, features: 8'h00};
            txValid <= 1'b0; txData <= 8'h00; protoActive <= 1'b0; securityClear <= 1'b0;
            cmdValid <= 1'b0; cmdData <= 8'h00; ppsGood <= 1'b0; ppsBad <= 1'b0;
            parityCheckEn <= 1'b1;
        end else if (ce) begin
            state <= next_state; coldPend <= next_coldPend; txPps <= next_txPps;
            idx <= next_idx; txLen <= next_txLen; ta1S <= next_ta1S; ta3S <= next_ta3S; tb3S <= next_tb3S;
            ppsBuf <= next_ppsBuf; ppsCnt <= next_ppsCnt; ppsLen <= next_ppsLen; linkCfg <= next_linkCfg;
            txValid <= next_txValid; txData <= next_txData; protoActive <= next_protoActive;
            securityClear <= next_securityClear; cmdValid <= next_cmdValid; cmdData <= next_cmdData;
            ppsGood <= next_ppsGood; ppsBad <= next_ppsBad;
            parityCheckEn <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Card clock supervision; a stopped clock is inferred from missing edges
    logic [10:0] sinceTx, sinceRst, next_sinceTx, next_sinceRst;
    logic [7:0]  idle, next_idle;
    logic        clkStopped, armed, next_clkStopped, next_armed, next_stopEarly, next_stopForbid, next_cmdEarly;
    always_comb begin
        next_sinceTx = sinceTx; next_sinceRst = sinceRst; next_idle = idle;
        next_clkStopped = clkStopped; next_armed = armed;
        next_stopEarly  = stopEarly  & ~(wrStat & regWdata[5]);
        next_stopForbid = stopForbid & ~(wrStat & regWdata[6]);
        next_cmdEarly   = cmdEarly   & ~(wrStat & regWdata[7]);
        if (clkRise) begin
            next_idle = 8'h00;
            if (sinceTx != `LCNT_MAX) next_sinceTx = sinceTx + 11'h1;
            if (clkStopped) begin
                next_clkStopped = 1'b0; next_sinceRst = 11'h0; next_armed = 1'b1;
            end else if (sinceRst != `LCNT_MAX) begin
                next_sinceRst = sinceRst + 11'h1;
            end
        end else if (idle != 8'(STOP_IDLE_CYC)) begin
            next_idle = idle + 8'h1;
        end else if (!clkStopped && protoActive) begin
            next_clkStopped = 1'b1;
            if (sinceTx < `STOP_MIN_LCYC) next_stopEarly = 1'b1;
            if (clkInd(ta3S) < 8'h40) next_stopForbid = 1'b1;
        end
        if (txDone) next_sinceTx = 11'h0;
        if (rxChar.valid && armed) begin
            next_armed = 1'b0;
            if (sinceRst < `RESTART_MIN_LCYC) next_cmdEarly = 1'b1;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sinceTx <= `LCNT_MAX; sinceRst <= `LCNT_MAX; idle <= 8'h00;
            clkStopped <= 1'b0; armed <= 1'b0;
            stopEarly <= 1'b0; stopForbid <= 1'b0; cmdEarly <= 1'b0;
        end else if (ce) begin
            sinceTx <= next_sinceTx; sinceRst <= next_sinceRst; idle <= next_idle;
            clkStopped <= next_clkStopped; armed <= next_armed;
            stopEarly <= next_stopEarly; stopForbid <= next_stopForbid; cmdEarly <= next_cmdEarly;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst || !ce);
    sequence ppsLastOut;
        state == ST_SEND && txPps && txValid && txReady && idx + 4'h1 == txLen;
    endsequence
    chk_atr_t15_mark:    assert property (txValid && !txPps && idx == 4'h4 |-> txData == `ATR_TD2)
        else $error("T=15 indicator missing");
    chk_atr_feat_map:    assert property (txValid && !txPps && idx == 4'h6 |-> txData == tb3S)
        else $error("feature byte wrong");
    chk_default_pair:    assert property (state == ST_FIRST |-> linkCfg.fiDi == `DEF_FIDI)
        else $error("non-default factors before PPS");
    chk_cold_negotiable: assert property ($fell(coldPend) |-> !linkCfg.specific && securityClear)
        else $error("cold reset not negotiable");
    chk_warm_keeps:      assert property (state == ST_SEND && linkCfg.specific |=> $stable(linkCfg.fiDi))
        else $error("specific mode lost factors");
    chk_atr_frozen:      assert property ($changed(ta3S) |-> $past(coldPend))
        else $error("warm reset changed answer");
    chk_clkstop_ind:     assert property (txValid && !txPps && idx == 4'h5
                                          |-> txData[7:6] != 2'h0 || txData[5:0] == `CLASS_A_ONLY)
        else $error("clock stop wrongly barred");
    chk_parity_drop:     assert property (rxChar.valid && rxChar.parityErr |=> !cmdValid && parityCheckEn)
        else $error("bad parity byte passed");
    chk_proto_start:     assert property (ppsLastOut |=> protoActive ##1 protoActive || !rstHi)
        else $error("protocol not started");
endmodule : card_reset_ctrl

// file: include/card_ctrl_defs.svh
// Offsets, reset values, byte codes and cycle counts of the card reset and negotiation control
`ifndef CARD_CTRL_DEFS_SVH
`define CARD_CTRL_DEFS_SVH
`define OFS_CTRL         8'h00
`define OFS_TA1          8'h04
`define OFS_CLKCLS       8'h08
`define OFS_FEAT         8'h0C
`define OFS_STAT         8'h10
`define OFS_NEG          8'h14
`define RST_TA1          8'h95
`define RST_CLKCLS       8'h43
`define RST_FEAT         8'h00
`define DEF_FIDI         8'h11
`define FIDI_512_8       8'h94
`define FIDI_512_16      8'h95
`define ATR_TS           8'h3B
`define ATR_T0           8'h90
`define ATR_TD1          8'h80
`define ATR_TD2          8'h3F
`define ATR_LEN          4'h8
`define PPSS_CODE        8'hFF
`define CLASS_A_ONLY     6'h01
`define STOP_MIN_LCYC    11'h744
`define RESTART_MIN_LCYC 11'h2E8
`define LCNT_MAX         11'h7FF
`endif

// file: include/card_ctrl_pkg.sv
// Types shared by the card reset and negotiation control
package card_ctrl_pkg;
    typedef enum logic [2:0] {ST_HELD, ST_SEND, ST_FIRST, ST_PPS, ST_MUTE, ST_ACTIVE} ctrlState_e;
    typedef struct packed {
        logic       valid;
        logic       parityErr;
        logic [7:0] data;
    } rxChar_s;
    typedef struct packed {
        logic       specific;
        logic [7:0] fiDi;
        logic [7:0] features;
    } linkCfg_s;
endpackage : card_ctrl_pkg

// file: dv/terminal_model.sv
// Terminal side model: link clock, character layer handshake and byte capture
`timescale 1ns/100ps
module terminal_model (
    // Bench side
    input  wire logic                 core_clk,
    input  wire logic                 clkRun,
    // Card character layer
    input  wire logic                 txValid,
    input  wire logic [7:0]           txData,
    output card_ctrl_pkg::rxChar_s    rxChar,
    output logic                      txReady,
    output logic                      txDone,
    output logic                      cardClk
);
    import card_ctrl_pkg::*;
    logic [7:0] seen [$];
    logic [1:0] slow = 2'h0;
    initial begin
        rxChar = '0;
        txReady = 1'b0;
        txDone = 1'b0;
        cardClk = 1'b0;
    end
    // Clock runs whenever clkRun is high, sessions or not; stopping it is left to the bench
    always #80 if (clkRun) cardClk = ~cardClk;
    // Ready alternates two slow and two prompt cycles
    always @(posedge core_clk) begin
        slow <= slow + 2'h1;
        txReady <= slow[1];
        txDone <= txValid && txReady;
        if (txValid && txReady) seen.push_back(txData);
    end
    // No parity signalling from the terminal side during answer-to-reset; pe marks a damaged character
    task automatic sendChar(input logic [7:0] b, input logic pe = 1'b0);
        @(posedge core_clk);
        rxChar <= '{valid: 1'b1, parityErr: pe, data: b};
        @(posedge core_clk);
        rxChar <= '{valid: 1'b0, parityErr: 1'b0, data: ~b};
        repeat (12) @(posedge core_clk);
    endtask : sendChar
endmodule : terminal_model

// file: dv/testbench.sv
// Self-checking bench for the card reset and negotiation control
`timescale 1ns/100ps
`include "card_ctrl_defs.svh"
module testbench;
    import card_ctrl_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, cardVcc = 1'b0, cardRstN = 1'b0, clkRun = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0, txReady, txDone, txValid, parityCheckEn, protoActive;
    logic securityClear, cmdValid, cardClk, cardClkIn;
    logic [7:0] regAddr = 8'h00, txData, cmdData, lastCmd = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, rd;
    rxChar_s rxChar;
    linkCfg_s linkCfg;
    int fails = 0, num_checks = 0, clears = 0, cycles = 0;
    logic [7:0] atr [8] = '{8'h3B, 8'h90, 8'h95, 8'h80, 8'h3F, 8'h43, 8'h00, 8'hF9};
    assign cardClkIn = cardClk;
    always #10 core_clk = ~core_clk;
    card_reset_ctrl #(.STOP_IDLE_CYC(32)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
        .cardVcc(cardVcc), .cardRstN(cardRstN), .cardClk(cardClkIn), .rxChar(rxChar), .txReady(txReady),
        .txDone(txDone), .txValid(txValid), .txData(txData), .parityCheckEn(parityCheckEn),
        .protoActive(protoActive), .securityClear(securityClear), .cmdValid(cmdValid), .cmdData(cmdData),
        .linkCfg(linkCfg), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata));
    terminal_model term (.core_clk(core_clk), .clkRun(clkRun), .txValid(txValid), .txData(txData),
        .rxChar(rxChar), .txReady(txReady), .txDone(txDone), .cardClk(cardClk));
    always @(posedge core_clk) begin
        if (securityClear === 1'b1) clears++;
        if (cmdValid === 1'b1) lastCmd <= cmdData;
        if (++cycles == 60000) begin
            fails++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seenVal, input logic [31:0] exp);
        num_checks++;
        if (seenVal !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seenVal, exp);
        end
    endtask : check
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(posedge core_clk);
        rd = regRdata;
    endtask : regRead
    task automatic waitBytes(input int n);
        for (int i = 0; i < 2000 && term.seen.size() < n; i++) @(posedge core_clk);
        // One more edge so that state launched by the last byte has settled
        @(posedge core_clk);
        check(32'(term.seen.size()), 32'(n));
    endtask : waitBytes
    // Answer-to-reset must come back byte for byte as held in atr, which the bench updates after a cold reset
    task automatic cardReset();
        term.seen.delete();
        @(posedge core_clk);
        cardRstN <= 1'b0;
        repeat (8) @(posedge core_clk);
        cardRstN <= 1'b1;
        waitBytes(8);
        for (int i = 0; i < 8; i++) check({24'h0, term.seen.pop_front()}, {24'h0, atr[i]});
    endtask : cardReset
    task automatic sendPps(input logic [7:0] pck);
        term.sendChar(8'hFF);
        term.sendChar(8'h10);
        term.sendChar(8'h94);
        term.sendChar(pck);
    endtask : sendPps
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        check({31'h0, parityCheckEn}, 32'h1);
        check({15'h0, linkCfg}, {15'h0, 1'b0, `DEF_FIDI, 8'h00});
        regRead(`OFS_TA1);
        check(rd, {24'h0, `RST_TA1});
        regRead(`OFS_CLKCLS);
        check(rd, {24'h0, `RST_CLKCLS});
        regRead(`OFS_FEAT);
        check(rd, {24'h0, `RST_FEAT});
        regRead(8'h3C);
        check(rd, 32'h0);
    endtask : test_regs
    task automatic test_cold_pps();
        cardVcc <= 1'b1;
        clkRun <= 1'b1;
        repeat (4) @(posedge core_clk);
        cardReset();
        check(32'(clears), 32'h1);
        check({31'h0, protoActive}, 32'h0);
        term.seen.delete();
        sendPps(8'h7B);
        waitBytes(4);
        for (int i = 0; i < 4; i++) check({24'h0, term.seen.pop_front()}, {24'h0, i == 0 ? 8'hFF : i == 1 ? 8'h10 : i == 2 ? 8'h94 : 8'h7B});
        check({31'h0, protoActive}, 32'h1);
        check({24'h0, linkCfg.fiDi}, {24'h0, `FIDI_512_8});
        // Stop the clock right after the echo; command as soon as the restart is seen
        clkRun <= 1'b0;
        repeat (60) @(posedge core_clk);
        clkRun <= 1'b1;
        repeat (20) @(posedge core_clk);
        term.sendChar(8'hA4);
        regRead(`OFS_STAT);
        check(rd & 32'hE0, 32'hA0);
    endtask : test_cold_pps
    task automatic test_specific();
        regWrite(`OFS_CTRL, 32'h1);
        // New feature byte must not reach the answer before the next cold reset
        regWrite(`OFS_FEAT, 32'h01);
        regRead(`OFS_FEAT);
        check(rd, 32'h1);
        cardReset();
        check(32'(clears), 32'h2);
        check({31'h0, protoActive}, 32'h1);
        check({15'h0, linkCfg}, {15'h0, 1'b1, `FIDI_512_8, 8'h00});
    endtask : test_specific
    task automatic test_negotiable();
        regWrite(`OFS_CTRL, 32'h0);
        cardReset();
        check({24'h0, linkCfg.fiDi}, {24'h0, `DEF_FIDI});
        term.sendChar(8'hA0);
        check({31'h0, protoActive}, 32'h1);
        check({24'h0, lastCmd}, 32'hA0);
        regWrite(`OFS_STAT, 32'hFF);
        cardReset();
        sendPps(8'h00);
        check(32'(term.seen.size()), 32'h0);
        regRead(`OFS_STAT);
        check(rd & 32'h14, 32'h10);
        cardReset();
    endtask : test_negotiable
    // Reset pin and power drop in the same cycle; power returns while reset is still held low
    task automatic test_recold();
        regWrite(`OFS_CTRL, 32'h1);
        regWrite(`OFS_CLKCLS, 32'h01);
        cardRstN <= 1'b0;
        cardVcc <= 1'b0;
        repeat (8) @(posedge core_clk);
        cardVcc <= 1'b1;
        atr[5] = 8'h01;
        atr[6] = 8'h01;
        atr[7] = 8'hBA;
        cardReset();
        check(32'(clears), 32'h6);
        check({15'h0, linkCfg}, {15'h0, 1'b0, `DEF_FIDI, 8'h00});
        term.sendChar(8'h5A);
        check({24'h0, lastCmd}, 32'h5A);
        term.sendChar(8'h66, 1'b1);
        check({24'h0, lastCmd}, 32'h5A);
        ce <= 1'b0;
        term.sendChar(8'h77);
        ce <= 1'b1;
        check({24'h0, lastCmd}, 32'h5A);
        regWrite(`OFS_STAT, 32'hFF);
        clkRun <= 1'b0;
        repeat (60) @(posedge core_clk);
        clkRun <= 1'b1;
        repeat (20) @(posedge core_clk);
        regRead(`OFS_STAT);
        check(rd & 32'hE0, 32'h60);
    endtask : test_recold
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        test_regs();
        test_cold_pps();
        test_specific();
        test_negotiable();
        test_recold();
        end_sim();
    end
endmodule : testbench
